/* File: design/lmx_pkg.sv */
// Package of constants and types for the LED matrix control register bank.
package lmx_pkg;
  localparam logic [7:0] OFS_CLOCK_SELECT = 8'h10;
  localparam logic [7:0] OFS_COL_EN_LOW = 8'h11;
  localparam logic [7:0] OFS_COL_EN_MID = 8'h12;
  localparam logic [7:0] OFS_COL_EN_HIGH = 8'h13;
  localparam logic [7:0] OFS_ROW_EN = 8'h14;
  localparam logic [7:0] OFS_BLANK_INTERVAL = 8'h15;
  localparam logic [7:0] OFS_STEP_UP = 8'h16;
  localparam logic [7:0] OFS_VISUAL = 8'h20;
  localparam logic [7:0] OFS_PWM_LEVEL = 8'h21;
  localparam logic [7:0] OFS_SCROLL_SPD_DIR = 8'h30;
  localparam logic [7:0] OFS_SCROLL_BLANK = 8'h31;
  localparam logic [7:0] OFS_SCROLL_WAIT = 8'h32;
  localparam logic [7:0] OFS_COL_HOLD_LOW = 8'h33;
  localparam logic [7:0] OFS_COL_HOLD_MID = 8'h34;
  localparam logic [7:0] OFS_COL_HOLD_HIGH = 8'h35;
  localparam logic [7:0] OFS_ROW_HOLD = 8'h36;
  localparam logic [7:0] OFS_EVENT_MASK = 8'h40;
  localparam logic [7:0] OFS_EVENT_LATCH = 8'h41;
  localparam logic [7:0] OFS_LIVE_COND = 8'h42;
  localparam logic [7:0] OFS_SCROLL_STEPS = 8'h43;
  localparam logic [7:0] OFS_REVISION = 8'hff;

  localparam logic [7:0] RST_CLOCK_SELECT = 8'h00;
  localparam logic [7:0] RST_COL_EN = 8'hff;
  localparam logic [7:0] RST_ROW_EN = 8'h1f;
  localparam logic [7:0] RST_STEP_UP = 8'h0a;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_LIVE_COND = 8'h20;

  localparam logic [7:0] MSK_CLOCK_SELECT = 8'h1f;
  localparam logic [7:0] MSK_ROW = 8'h1f;
  localparam logic [7:0] MSK_BLANK = 8'h07;
  localparam logic [7:0] MSK_STEP_UP = 8'h8f;
  localparam logic [7:0] MSK_VISUAL = 8'h3f;
  localparam logic [7:0] MSK_SCROLL_WAIT = 8'h3f;
  localparam logic [7:0] MSK_COL_HOLD_MID = 8'h3f;
  localparam logic [7:0] MSK_LIVE_COND = 8'hef;
  localparam logic [7:0] MSK_STEPS = 8'h3f;
  localparam logic [7:0] MSK_REVISION = 8'h0f;

  localparam int EVT_SCROLL_DONE = 5;
  localparam int EVT_SCROLL_STEP = 4;
  localparam int RAMP_SLOPE_LSB = 2;
  localparam int RAMP_UNIT_CYCLES = 4;

  // Register-port request as seen from the serial front end.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } lmx_req_t;

  // Per-dot pattern word: dimming byte then slope/delay byte.
  typedef struct packed {
    logic [7:0] dimming;
    logic [7:0] slope_delay;
  } lmx_dot_t;

  typedef struct packed {
    logic step_up_ok_flag;
    logic row_short_flag;
    logic scroll_done_flag;
    logic scroll_step_flag;
    logic ref_short_flag;
    logic ref_open_flag;
    logic overtemp_flag;
    logic overvoltage_flag;
  } lmx_events_t;

  // Even byte address of a dot: two bytes per dot, five rows per column.
  function automatic logic [7:0] lmx_dot_addr(input logic [4:0] col, input logic [2:0] row);
    lmx_dot_addr = 8'((({3'h0, col} * 8'h05) + {5'h00, row}) << 1);
  endfunction : lmx_dot_addr
endpackage : lmx_pkg

/* File: design/lmx_event_latch.sv */
// Sticky event latch gated by the mask and cleared by a host read.
module lmx_event_latch (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] mask,
  input wire logic [7:0] events,
  input wire logic rd_clear,
  output logic [7:0] latch_ff
);
  import lmx_pkg::*;
  wire logic [7:0] set_bits = events & mask;
  wire logic [7:0] nxt_latch = (rd_clear ? 8'h00 : latch_ff) | set_bits;

  // A set arriving with the clearing read survives, so no event is lost.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      latch_ff <= RST_ZERO;
    end else begin
      latch_ff <= nxt_latch;
    end
  end

  mask_gate_a: assert property (@(posedge clk) disable iff (!rst_b)
    (latch_ff & ~$past(latch_ff) & ~$past(mask)) == 8'h00)
    else $error("latch bit set by a masked event");
  read_clear_a: assert property (@(posedge clk) disable iff (!rst_b)
    (rd_clear && ((events & mask) == 8'h00)) |=> (latch_ff == 8'h00))
    else $error("latch not cleared by read");
endmodule : lmx_event_latch

/* File: design/lmx_dot_ramp.sv */
// Brightness ramp of one dot toward its dimming byte at a slope-set rate.
module lmx_dot_ramp #(
  parameter int UNIT_CYCLES = lmx_pkg::RAMP_UNIT_CYCLES
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ramp_enable,
  input wire lmx_pkg::lmx_dot_t dot,
  output logic [7:0] level_ff
);
  import lmx_pkg::*;
  logic [7:0] tick_cnt_ff;
  wire logic [1:0] slope = dot.slope_delay[RAMP_SLOPE_LSB +: 2];
  // Larger slope means more cycles per step, so slope 1 ramps fastest.
  wire logic [7:0] step_period = 8'(slope * UNIT_CYCLES);
  wire logic tick = (tick_cnt_ff + 8'h01 >= step_period);
  wire logic direct = !ramp_enable || (slope == 2'h0);
  wire logic [7:0] nxt_level = direct ? dot.dimming :
    (tick && level_ff < dot.dimming) ? level_ff + 8'h01 :
    (tick && level_ff > dot.dimming) ? level_ff - 8'h01 : level_ff;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tick_cnt_ff <= 8'h00;
      level_ff <= 8'h00;
    end else begin
      tick_cnt_ff <= (tick || direct) ? 8'h00 : tick_cnt_ff + 8'h01;
      level_ff <= nxt_level;
    end
  end

  ramp_step_a: assert property (@(posedge clk) disable iff (!rst_b)
    (!direct && $stable(dot) && $stable(ramp_enable)) |=>
      (level_ff - $past(level_ff) <= 8'h01) || ($past(level_ff) - level_ff <= 8'h01))
    else $error("ramp moved more than one step");
  direct_level_a: assert property (@(posedge clk) disable iff (!rst_b)
    direct |=> (level_ff == $past(dot.dimming)))
    else $error("dot level does not follow dimming byte");
endmodule : lmx_dot_ramp

/* File: design/lmx_ctrl_regs.sv */
// Control and status register bank of the 5x24 LED matrix driver.
module lmx_ctrl_regs #(
  parameter logic [3:0] REVISION = 4'h3, // Arbitrary value.
  parameter int RAMP_UNIT = lmx_pkg::RAMP_UNIT_CYCLES
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire lmx_pkg::lmx_req_t req,
  input wire lmx_pkg::lmx_events_t events,
  input wire logic matrix_enable,
  input wire logic [7:0] live_in,
  input wire logic [5:0] step_count_in,
  input wire lmx_pkg::lmx_dot_t dot_in,
  output logic [7:0] rdata_ff,
  output logic [7:0] latch_out_ff,
  output logic [4:0] clock_cfg_ff,
  output logic [23:0] column_driver_on_ff,
  output logic [4:0] row_driver_on_ff,
  output logic [2:0] blank_interval_code_ff,
  output logic step_up_enable_ff,
  output logic [3:0] step_up_voltage_code_ff,
  output logic [5:0] visual_ff,
  output logic [7:0] pwm_level_ff,
  output logic [5:0] scroll_speed_ff,
  output logic [1:0] scroll_direction_ff,
  output logic [2:0] blank_row_count_ff,
  output logic [4:0] blank_column_count_ff,
  output logic [5:0] scroll_wait_ff,
  output logic [23:0] column_hold_ff,
  output logic [4:0] row_hold_ff,
  output logic [7:0] dot_level_ff,
  output logic [7:0] dot_addr_ff
);
  import lmx_pkg::*;

  logic rst_sync1_ff;
  logic rst_sync2_ff;
  wire logic rst_i_b = rst_sync2_ff;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_sync1_ff <= 1'b0;
      rst_sync2_ff <= 1'b0;
    end else begin
      rst_sync1_ff <= 1'b1;
      rst_sync2_ff <= rst_sync1_ff;
    end
  end

  logic [7:0] clock_sel_ff;
  logic [7:0] col_en_ff [3];
  logic [7:0] row_en_ff;
  logic [7:0] blank_ff;
  logic [7:0] step_up_ff;
  logic [7:0] visual_reg_ff;
  logic [7:0] pwm_ff;
  logic [7:0] scroll_sd_ff;
  logic [7:0] scroll_blank_ff;
  logic [7:0] wait_ff;
  logic [7:0] col_hold_ff [3];
  logic [7:0] row_hold_reg_ff;
  logic [7:0] mask_ff;
  logic [7:0] live_ff;
  logic [7:0] steps_ff;
  logic [7:0] latch_q;
  logic [7:0] ramp_level;

  wire logic wr = req.wr && !req.rd;
  wire logic rd = req.rd;
  wire logic [7:0] wd = req.wdata;
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  wire logic [1:0] col_en_idx = 2'(req.addr - OFS_COL_EN_LOW);
  wire logic [1:0] col_hold_idx = 2'(req.addr - OFS_COL_HOLD_LOW);
  wire logic col_en_hit = (req.addr >= OFS_COL_EN_LOW) && (req.addr <= OFS_COL_EN_HIGH);
  wire logic col_hold_hit = (req.addr >= OFS_COL_HOLD_LOW) && (req.addr <= OFS_COL_HOLD_HIGH);
  wire logic latch_read = rd && hit(req.addr, OFS_EVENT_LATCH);
  wire logic [7:0] hold_mask = (col_hold_idx == 2'h1) ? MSK_COL_HOLD_MID : 8'hff;

  // Scroll done is seen in status and in the latch; the step event has no live bit.
  wire logic [7:0] nxt_live = live_in & MSK_LIVE_COND;
  wire logic [7:0] nxt_rdata =
    hit(req.addr, OFS_CLOCK_SELECT) ? clock_sel_ff :
    col_en_hit ? col_en_ff[col_en_idx] :
    hit(req.addr, OFS_ROW_EN) ? row_en_ff :
    hit(req.addr, OFS_BLANK_INTERVAL) ? blank_ff :
    hit(req.addr, OFS_STEP_UP) ? step_up_ff :
    hit(req.addr, OFS_VISUAL) ? visual_reg_ff :
    hit(req.addr, OFS_PWM_LEVEL) ? pwm_ff :
    hit(req.addr, OFS_SCROLL_SPD_DIR) ? scroll_sd_ff :
    hit(req.addr, OFS_SCROLL_WAIT) ? wait_ff :
    col_hold_hit ? col_hold_ff[col_hold_idx] :
    hit(req.addr, OFS_ROW_HOLD) ? row_hold_reg_ff :
    hit(req.addr, OFS_EVENT_MASK) ? mask_ff :
    hit(req.addr, OFS_EVENT_LATCH) ? latch_q :
    hit(req.addr, OFS_LIVE_COND) ? live_ff :
    hit(req.addr, OFS_SCROLL_STEPS) ? steps_ff :
    hit(req.addr, OFS_REVISION) ? ({4'h0, REVISION} & MSK_REVISION) :
    8'h00; // Write-only and unmapped addresses read as zero.

  // Writes to the clock register are accepted only while the matrix is off.
  wire logic clock_wr_ok = wr && hit(req.addr, OFS_CLOCK_SELECT) && !matrix_enable;

  always_ff @(posedge clk or negedge rst_i_b) begin
    if (!rst_i_b) begin
      clock_sel_ff <= RST_CLOCK_SELECT;
      row_en_ff <= RST_ROW_EN;
      blank_ff <= RST_ZERO;
      step_up_ff <= RST_STEP_UP;
      visual_reg_ff <= RST_ZERO;
      pwm_ff <= RST_ZERO;
    end else begin
      if (clock_wr_ok) clock_sel_ff <= wd & MSK_CLOCK_SELECT;
      if (wr && hit(req.addr, OFS_ROW_EN)) row_en_ff <= wd & MSK_ROW;
      if (wr && hit(req.addr, OFS_BLANK_INTERVAL)) blank_ff <= wd & MSK_BLANK;
      if (wr && hit(req.addr, OFS_STEP_UP)) step_up_ff <= wd & MSK_STEP_UP;
      if (wr && hit(req.addr, OFS_VISUAL)) visual_reg_ff <= wd & MSK_VISUAL;
      if (wr && hit(req.addr, OFS_PWM_LEVEL)) pwm_ff <= wd;
    end
  end

  always_ff @(posedge clk or negedge rst_i_b) begin
    if (!rst_i_b) begin
      col_en_ff <= '{RST_COL_EN, RST_COL_EN, RST_COL_EN};
    end else if (wr && col_en_hit) begin
      col_en_ff[col_en_idx] <= wd;
    end
  end

  // The host is trusted to leave the scroll registers here alone while a scroll runs; the event mask has no such rule.
  always_ff @(posedge clk or negedge rst_i_b) begin
    if (!rst_i_b) begin
      scroll_sd_ff <= RST_ZERO;
      scroll_blank_ff <= RST_ZERO;
      wait_ff <= RST_ZERO;
      col_hold_ff <= '{RST_ZERO, RST_ZERO, RST_ZERO};
      row_hold_reg_ff <= RST_ZERO;
      mask_ff <= RST_ZERO;
    end else begin
      if (wr && hit(req.addr, OFS_SCROLL_SPD_DIR)) scroll_sd_ff <= wd;
      if (wr && hit(req.addr, OFS_SCROLL_BLANK)) scroll_blank_ff <= wd;
      if (wr && hit(req.addr, OFS_SCROLL_WAIT)) wait_ff <= wd & MSK_SCROLL_WAIT;
      if (wr && col_hold_hit) col_hold_ff[col_hold_idx] <= wd & hold_mask;
      if (wr && hit(req.addr, OFS_ROW_HOLD)) row_hold_reg_ff <= wd & MSK_ROW;
      if (wr && hit(req.addr, OFS_EVENT_MASK)) mask_ff <= wd;
    end
  end

  always_ff @(posedge clk or negedge rst_i_b) begin
    if (!rst_i_b) begin
      live_ff <= RST_LIVE_COND;
      steps_ff <= RST_ZERO;
      rdata_ff <= RST_ZERO;
    end else begin
      live_ff <= nxt_live;
      steps_ff <= {2'h0, step_count_in} & MSK_STEPS;
      if (rd) rdata_ff <= nxt_rdata;
    end
  end

  lmx_event_latch u_latch (
    .clk(clk),
    .rst_b(rst_i_b),
    .mask(mask_ff),
    .events(events),
    .rd_clear(latch_read),
    .latch_ff(latch_q)
  );

  lmx_dot_ramp #(.UNIT_CYCLES(RAMP_UNIT)) u_ramp (
    .clk(clk),
    .rst_b(rst_i_b),
    .ramp_enable(visual_reg_ff[3]),
    .dot(dot_in),
    .level_ff(ramp_level)
  );

  // Register copies of the fields feed the display logic directly.
  always_ff @(posedge clk or negedge rst_i_b) begin
    if (!rst_i_b) begin
      latch_out_ff <= RST_ZERO;
      clock_cfg_ff <= 5'h00;
      column_driver_on_ff <= {RST_COL_EN, RST_COL_EN, RST_COL_EN};
      row_driver_on_ff <= 5'h1f;
      blank_interval_code_ff <= 3'h0;
      step_up_enable_ff <= 1'b0;
      step_up_voltage_code_ff <= 4'ha;
      visual_ff <= 6'h00;
      pwm_level_ff <= 8'h00;
      scroll_speed_ff <= 6'h00;
      scroll_direction_ff <= 2'h0;
      blank_row_count_ff <= 3'h0;
      blank_column_count_ff <= 5'h00;
      scroll_wait_ff <= 6'h00;
      column_hold_ff <= 24'h000000;
      row_hold_ff <= 5'h00;
      dot_level_ff <= 8'h00;
      dot_addr_ff <= 8'h00;
    end else begin
      latch_out_ff <= latch_q;
      clock_cfg_ff <= clock_sel_ff[4:0];
      column_driver_on_ff <= {col_en_ff[2], col_en_ff[1], col_en_ff[0]};
      row_driver_on_ff <= row_en_ff[4:0];
      blank_interval_code_ff <= blank_ff[2:0];
      step_up_enable_ff <= step_up_ff[7];
      step_up_voltage_code_ff <= step_up_ff[3:0];
      visual_ff <= visual_reg_ff[5:0];
      pwm_level_ff <= pwm_ff;
      scroll_speed_ff <= scroll_sd_ff[7:2];
      scroll_direction_ff <= scroll_sd_ff[1:0];
      blank_row_count_ff <= scroll_blank_ff[7:5];
      blank_column_count_ff <= scroll_blank_ff[4:0];
      scroll_wait_ff <= wait_ff[5:0];
      column_hold_ff <= {col_hold_ff[2], col_hold_ff[1], col_hold_ff[0]};
      row_hold_ff <= row_hold_reg_ff[4:0];
      dot_level_ff <= ramp_level;
      // Dot address from column and row carried on the slope/delay byte.
      dot_addr_ff <= lmx_dot_addr(dot_in.slope_delay[4:0], dot_in.slope_delay[7:5]);
    end
  end

  clock_lock_a: assert property (@(posedge clk) disable iff (!rst_i_b)
    (wr && hit(req.addr, OFS_CLOCK_SELECT) && matrix_enable) |=> $stable(clock_sel_ff))
    else $error("clock register changed while matrix enabled");
  row_reserved_a: assert property (@(posedge clk) disable iff (!rst_i_b)
    row_en_ff[7:5] == 3'h0 && blank_ff[7:3] == 5'h00 && step_up_ff[6:4] == 3'h0)
    else $error("reserved bits not zero");
  wo_read_zero_a: assert property (@(posedge clk) disable iff (!rst_i_b)
    (rd && hit(req.addr, OFS_SCROLL_BLANK)) |=> (rdata_ff == 8'h00))
    else $error("write-only register read back");
  rev_read_a: assert property (@(posedge clk) disable iff (!rst_i_b)
    (rd && hit(req.addr, OFS_REVISION)) |=> (rdata_ff == {4'h0, REVISION}))
    else $error("revision read wrong");
  pwm_write_a: assert property (@(posedge clk) disable iff (!rst_i_b)
    (wr && hit(req.addr, OFS_PWM_LEVEL)) |=> ##1 (pwm_level_ff == $past(wd, 2)))
    else $error("pwm level not taken");
  col_en_write_a: assert property (@(posedge clk) disable iff (!rst_i_b)
    (wr && hit(req.addr, OFS_COL_EN_MID)) |=> ##1 (column_driver_on_ff[15:8] == $past(wd, 2)))
    else $error("column enable write lost");
  live_no_step_a: assert property (@(posedge clk) disable iff (!rst_i_b)
    live_ff[EVT_SCROLL_STEP] == 1'b0)
    else $error("status has a step bit");
  step_up_a: assert property (@(posedge clk) disable iff (!rst_i_b)
    (wr && hit(req.addr, OFS_STEP_UP)) |=> ##1
      (step_up_enable_ff == $past(wd[7], 2) && step_up_voltage_code_ff == $past(wd[3:0], 2)))
    else $error("step-up control write lost");

  // A write lands in the register at once and in the output copy one edge later.
  row_write_a: assert property (@(posedge clk) disable iff (!rst_i_b)
    (wr && hit(req.addr, OFS_ROW_EN)) |=> (row_en_ff == {3'h0, $past(wd[4:0])}))
    else $error("row enable write wrong");
  blank_write_a: assert property (@(posedge clk) disable iff (!rst_i_b)
    (wr && hit(req.addr, OFS_BLANK_INTERVAL)) |=> (blank_ff == {5'h00, $past(wd[2:0])}))
    else $error("blanking code write wrong");
  visual_write_a: assert property (@(posedge clk) disable iff (!rst_i_b)
    (wr && hit(req.addr, OFS_VISUAL)) |=> ##1 (visual_ff == $past(wd[5:0], 2)))
    else $error("visual control write lost");
  scroll_write_a: assert property (@(posedge clk) disable iff (!rst_i_b)
    (wr && hit(req.addr, OFS_SCROLL_SPD_DIR)) |=> ##1
      (scroll_speed_ff == $past(wd[7:2], 2) && scroll_direction_ff == $past(wd[1:0], 2)))
    else $error("scroll speed write lost");
  blank_count_a: assert property (@(posedge clk) disable iff (!rst_i_b)
    (wr && hit(req.addr, OFS_SCROLL_BLANK)) |=> ##1
      (blank_row_count_ff == $past(wd[7:5], 2) && blank_column_count_ff == $past(wd[4:0], 2)))
    else $error("blank count write lost");
  wait_write_a: assert property (@(posedge clk) disable iff (!rst_i_b)
    (wr && hit(req.addr, OFS_SCROLL_WAIT)) |=> ##1 (scroll_wait_ff == $past(wd[5:0], 2)))
    else $error("scroll wait write lost");
  hold_mid_a: assert property (@(posedge clk) disable iff (!rst_i_b)
    (wr && hit(req.addr, OFS_COL_HOLD_MID)) |=> ##1
      (column_hold_ff[15:8] == {2'h0, $past(wd[5:0], 2)}))
    else $error("column hold write wrong");
  row_hold_a: assert property (@(posedge clk) disable iff (!rst_i_b)
    (wr && hit(req.addr, OFS_ROW_HOLD)) |=> ##1 (row_hold_ff == $past(wd[4:0], 2)))
    else $error("row hold write lost");
  mask_write_a: assert property (@(posedge clk) disable iff (!rst_i_b)
    (wr && hit(req.addr, OFS_EVENT_MASK)) |=> (mask_ff == $past(wd)))
    else $error("event mask write lost");
  latch_read_a: assert property (@(posedge clk) disable iff (!rst_i_b)
    (rd && hit(req.addr, OFS_EVENT_LATCH)) |=> (rdata_ff == $past(latch_q)))
    else $error("latch read wrong");
  latch_copy_a: assert property (@(posedge clk) disable iff (!rst_i_b)
    1'b1 |=> (latch_out_ff == $past(latch_q)))
    else $error("latch copy wrong");
  live_follow_a: assert property (@(posedge clk) disable iff (!rst_i_b)
    1'b1 |=> (live_ff == {$past(live_in[7:5]), 1'b0, $past(live_in[3:0])}))
    else $error("status does not follow live conditions");
  steps_follow_a: assert property (@(posedge clk) disable iff (!rst_i_b)
    1'b1 |=> (steps_ff == {2'h0, $past(step_count_in)}))
    else $error("step count does not follow");
  dot_addr_a: assert property (@(posedge clk) disable iff (!rst_i_b)
    1'b1 |=> (dot_addr_ff == 8'(10 * $past(dot_in.slope_delay[4:0])
      + 2 * $past(dot_in.slope_delay[7:5]))))
    else $error("dot address wrong");
  col_en_low_a: assert property (@(posedge clk) disable iff (!rst_i_b)
    (wr && hit(req.addr, OFS_COL_EN_LOW)) |=> ##1 (column_driver_on_ff[7:0] == $past(wd, 2)))
    else $error("low column enable write lost");
  col_en_high_a: assert property (@(posedge clk) disable iff (!rst_i_b)
    (wr && hit(req.addr, OFS_COL_EN_HIGH)) |=> ##1 (column_driver_on_ff[23:16] == $past(wd, 2)))
    else $error("high column enable write lost");
  clock_write_a: assert property (@(posedge clk) disable iff (!rst_i_b)
    (wr && hit(req.addr, OFS_CLOCK_SELECT) && !matrix_enable) |=> ##1
      (clock_cfg_ff == $past(wd[4:0], 2)))
    else $error("clock register write lost");
  unmapped_read_a: assert property (@(posedge clk) disable iff (!rst_i_b)
    (rd && req.addr > OFS_SCROLL_STEPS && req.addr < OFS_REVISION) |=> (rdata_ff == 8'h00))
    else $error("unmapped read not zero");
endmodule : lmx_ctrl_regs

/* File: bench/lmx_host.sv */
// Host model that issues one-byte register requests to the bank.
module lmx_host (
  input wire logic clk,
  input wire logic matrix_enable,
  input wire logic scroll_done,
  input wire logic [7:0] rdata,
  output lmx_pkg::lmx_req_t req
);
  timeunit 1ns;
  timeprecision 1ns;
  import lmx_pkg::*;

  initial req = '0;

  // A released port shows toggled address and data, so stale values never look valid.
  task automatic release_bus(input logic [7:0] a, input logic [7:0] d);
    req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask : release_bus

  // The bad flag lets a scenario break the host-side write rules (clock lock, scroll-time writes) on purpose.
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d, input bit bad);
    if (bad || !((a == OFS_CLOCK_SELECT && matrix_enable)
        || (a >= OFS_SCROLL_SPD_DIR && a <= OFS_ROW_HOLD && !scroll_done))) begin
      @(posedge clk);
      req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk);
      release_bus(a, d);
    end
  endtask : write_reg

  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
    release_bus(a, 8'h00);
    #1;
    d = rdata;
  endtask : read_reg
endmodule : lmx_host

/* File: bench/tb_top.sv */
// Self-checking bench for the LED matrix control register bank.
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import lmx_pkg::*;
  localparam logic [3:0] REV = 4'h6; // Arbitrary value.
  localparam logic [7:0] RA [17] = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h20,
    8'h21, 8'h30, 8'h31, 8'h32, 8'h33, 8'h34, 8'h35, 8'h36, 8'h40};
  localparam logic [7:0] RR [17] = '{8'h00, 8'hff, 8'hff, 8'hff, 8'h1f, 8'h00, 8'h0a, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] RM [17] = '{8'h1f, 8'hff, 8'hff, 8'hff, 8'h1f, 8'h07, 8'h8f, 8'h3f,
    8'hff, 8'hff, 8'hff, 8'h3f, 8'hff, 8'h3f, 8'hff, 8'h1f, 8'hff};
  localparam logic [7:0] XA [6] = '{8'h41, 8'h42, 8'h43, 8'hff, 8'h50, 8'h17};
  localparam logic [4:0] DC [5] = '{5'd3, 5'd3, 5'd0, 5'd23, 5'd12};
  localparam logic [2:0] DR [5] = '{3'd0, 3'd1, 3'd4, 3'd4, 3'd2};
  logic clk, rst_b, matrix_enable;
  lmx_events_t events;
  lmx_req_t req;
  lmx_dot_t dot_in;
  logic [7:0] live_in, rdata_ff, latch_out_ff, pwm_level_ff, dot_level_ff, dot_addr_ff;
  logic [5:0] step_count_in, visual_ff, scroll_speed_ff, scroll_wait_ff;
  logic [4:0] clock_cfg_ff, row_driver_on_ff, blank_column_count_ff, row_hold_ff;
  logic [23:0] column_driver_on_ff, column_hold_ff;
  logic [3:0] step_up_voltage_code_ff;
  logic [2:0] blank_interval_code_ff, blank_row_count_ff;
  logic [1:0] scroll_direction_ff;
  logic step_up_enable_ff;
  logic [7:0] mdl [256];
  logic [7:0] wm [256];
  logic [7:0] latch_m;
  int fail_count, n_tests;

  lmx_ctrl_regs #(.REVISION(REV), .RAMP_UNIT(4)) DUT (.clk(clk), .rst_b(rst_b), .req(req),
    .events(events), .matrix_enable(matrix_enable), .live_in(live_in),
    .step_count_in(step_count_in), .dot_in(dot_in), .rdata_ff(rdata_ff),
    .latch_out_ff(latch_out_ff), .clock_cfg_ff(clock_cfg_ff),
    .column_driver_on_ff(column_driver_on_ff), .row_driver_on_ff(row_driver_on_ff),
    .blank_interval_code_ff(blank_interval_code_ff), .step_up_enable_ff(step_up_enable_ff),
    .step_up_voltage_code_ff(step_up_voltage_code_ff), .visual_ff(visual_ff),
    .pwm_level_ff(pwm_level_ff), .scroll_speed_ff(scroll_speed_ff),
    .scroll_direction_ff(scroll_direction_ff), .blank_row_count_ff(blank_row_count_ff),
    .blank_column_count_ff(blank_column_count_ff), .scroll_wait_ff(scroll_wait_ff),
    .column_hold_ff(column_hold_ff), .row_hold_ff(row_hold_ff),
    .dot_level_ff(dot_level_ff), .dot_addr_ff(dot_addr_ff));

  lmx_host host (.clk(clk), .matrix_enable(matrix_enable), .scroll_done(live_in[5]),
    .rdata(rdata_ff), .req(req));

  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : close_out

  task automatic chk_rd(input logic [7:0] a, input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t read of %h gave %h, expected %h", $time, a, got, exp);
    end
  endtask : chk_rd

  task automatic chk_out(input logic [127:0] got, input logic [127:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t %s gave %h, expected %h", $time, what, got, exp);
    end
  endtask : chk_out

  function automatic logic [7:0] exp_reg(input logic [7:0] a);
    case (a)
      OFS_SCROLL_BLANK: exp_reg = 8'h00;
      OFS_EVENT_LATCH: exp_reg = latch_m;
      OFS_LIVE_COND: exp_reg = live_in & 8'hef;
      OFS_SCROLL_STEPS: exp_reg = {2'b00, step_count_in};
      OFS_REVISION: exp_reg = {4'h0, REV};
      default: exp_reg = mdl[a];
    endcase
  endfunction : exp_reg

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input bit bad);
    host.write_reg(a, d, bad);
    if (!(a == OFS_CLOCK_SELECT && matrix_enable)) mdl[a] = d & wm[a];
  endtask : wr

  task automatic rd_chk(input logic [7:0] a);
    logic [7:0] d;
    logic [7:0] x;
    x = exp_reg(a);
    host.read_reg(a, d);
    if (a == OFS_EVENT_LATCH) latch_m = 8'h00;
    chk_rd(a, d, x);
  endtask : rd_chk

  task automatic chk_fields();
    repeat (2) @(posedge clk);
    #1;
    chk_out(128'({clock_cfg_ff, column_driver_on_ff, row_driver_on_ff, blank_interval_code_ff,
      step_up_enable_ff, step_up_voltage_code_ff, visual_ff, pwm_level_ff, scroll_speed_ff,
      scroll_direction_ff, blank_row_count_ff, blank_column_count_ff, scroll_wait_ff,
      column_hold_ff, row_hold_ff}), 128'({mdl[8'h10][4:0], mdl[8'h13], mdl[8'h12],
      mdl[8'h11], mdl[8'h14][4:0], mdl[8'h15][2:0], mdl[8'h16][7], mdl[8'h16][3:0],
      mdl[8'h20][5:0], mdl[8'h21], mdl[8'h30], mdl[8'h31], mdl[8'h32][5:0], mdl[8'h35],
      mdl[8'h34], mdl[8'h33], mdl[8'h36][4:0]}), "field outputs");
  endtask : chk_fields

  task automatic wait_level(input logic [7:0] lvl, output int n);
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (dot_level_ff !== lvl && n < 5000);
    chk_out(128'(dot_level_ff), 128'(lvl), "dot level");
  endtask : wait_level

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial begin
    #6000000;
    fail_count++;
    close_out();
  end

  initial begin : main
    int t [4];
    logic [7:0] e;
    rst_b = 1'b0;
    matrix_enable = 1'b0;
    events = '0;
    live_in = 8'h20;
    step_count_in = 6'h00;
    dot_in = '0;
    latch_m = 8'h00;
    fail_count = 0;
    n_tests = 0;
    for (int i = 0; i < 256; i++) begin
      mdl[i] = 8'h00;
      wm[i] = 8'h00;
    end
    for (int i = 0; i < 17; i++) begin
      mdl[RA[i]] = RR[i];
      wm[RA[i]] = RM[i];
    end
    void'($urandom(32'hfea5));
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    chk_fields();
    for (int i = 0; i < 17; i++) rd_chk(RA[i]);
    foreach (XA[i]) rd_chk(XA[i]);
    for (int p = 0; p < 2; p++) begin
      @(posedge clk);
      live_in <= 8'($urandom) | 8'h20;
      step_count_in <= 6'($urandom);
      for (int i = 0; i < 17; i++) wr(RA[i], 8'($urandom), 1'b0);
      foreach (XA[i]) wr(XA[i], 8'($urandom), 1'b0);
      chk_fields();
      for (int i = 0; i < 17; i++) rd_chk(RA[i]);
      foreach (XA[i]) rd_chk(XA[i]);
    end
    @(posedge clk);
    matrix_enable <= 1'b1;
    @(posedge clk);
    wr(OFS_CLOCK_SELECT, ~mdl[8'h10], 1'b1);
    chk_fields();
    rd_chk(OFS_CLOCK_SELECT);
    @(posedge clk);
    matrix_enable <= 1'b0;
    for (int k = 0; k < 4; k++) begin
      wr(OFS_EVENT_MASK, (k == 0) ? 8'h00 : 8'($urandom), 1'b0);
      e = 8'($urandom);
      @(posedge clk);
      events <= e;
      @(posedge clk);
      events <= '0;
      latch_m = latch_m | (e & mdl[8'h40]);
      repeat (2) @(posedge clk);
      chk_out(128'(latch_out_ff), 128'(latch_m), "latch copy");
      rd_chk(OFS_EVENT_LATCH);
      rd_chk(OFS_EVENT_LATCH);
    end
    foreach (DC[j]) begin
      @(posedge clk);
      dot_in <= '{dimming: 8'h00, slope_delay: {DR[j], DC[j]}};
      repeat (3) @(posedge clk);
      chk_out(128'(dot_addr_ff), 128'(2 * (5 * DC[j] + DR[j])), "dot address");
    end
    @(posedge clk);
    dot_in <= '{dimming: 8'h9c, slope_delay: 8'h00};
    wait_level(8'h9c, t[0]);
    // Ramp times grow with the slope; the order is checked, not the exact count.
    wr(OFS_VISUAL, 8'h08, 1'b0);
    for (int s = 1; s <= 3; s++) begin
      @(posedge clk);
      dot_in <= '{dimming: 8'h00, slope_delay: 8'h00};
      wait_level(8'h00, t[0]);
      @(posedge clk);
      dot_in <= '{dimming: 8'hff, slope_delay: 8'(s << 2)};
      wait_level(8'hff, t[s]);
    end
    chk_out(128'(t[1] < t[2] && t[2] < t[3]), 128'(1), "ramp order");
    close_out();
  end
endmodule : tb_top
